// [verilog/tsicr_top.sv]
// Switch control register with Wishbone slave, fill and alignment
// ---------------------------------------------------------------
// Function
// - Select bit turns pins 16-31 into indicators
// - Select clear keeps pins 16-31 as data while the mirror bit is clear
// - Mirror bit makes all pins enable indicators
// - Mirror clear gives normal switched data, except on pins 16-31 when select is set
// - Arm bit enables connection memory fill
// - Fill writes data high, clears low bits
// - Start rising edge with arm begins fill
// - Fill spans two complete frames
// - Completion clears start, arm and data
// - Drivers off when pin and standby low, except from reset to the first clock and on pins that the mirror or select bit drives
// - Evaluation start rising edge begins measurement
// - Align reference rising ends the measurement and sets the complete flag
// - Start falling clears complete flag, offset, except when a capture falls in the same cycle
// ---------------------------------------------------------------
`timescale 1ns/10ps
module tsicr_top
	import tsicr_pkg::*;
#(
	parameter int NS = NSTREAM
)(
	input  wire logic             clk,
	input  wire logic             rst_n,
	input  wire logic             wb_cyc_i,
	input  wire logic             wb_stb_i,
	input  wire logic             wb_we_i,
	input  wire logic [WB_AW-1:0] wb_adr_i,
	input  wire logic [3:0]       wb_sel_i,
	input  wire logic [31:0]      wb_dat_i,
	output logic      [31:0]      wb_dat_o,
	output logic                  wb_ack_o,
	output logic                  irq,
	input  wire logic             frame_pulse_pin,
	input  wire logic             align_ref_pin,
	input  wire logic             drive_enable_pin,
	input  wire logic [NS-1:0]    tx_data_in,
	input  wire logic [NS-1:0]    stream_active,
	output logic      [NS-1:0]    transmit_stream_pins,
	output logic      [NS-1:0]    transmit_stream_oe_n,
	output logic                  cm_we,
	output logic      [CM_AW-1:0] cm_addr,
	output logic      [CM_DW-1:0] cm_word
);
	// ---------------------------------------------------------------
	// State
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [1:0]      fp_s;
		logic            fp_d;
		logic [1:0]      ar_s;
		logic            ar_d;
		logic [1:0]      de_s;
		logic            enable_indication_select;
		logic            all_output_enable_mirror;
		logic            arm;
		logic [1:0]      fdat;
		logic            fstart;
		logic            output_standby;
		logic            estart;
		logic            ecomp;
		logic [OFF_W-1:0] eoff;
		logic [OFF_W-1:0] ecnt;
		tsicr_eval_st_t  est;
		logic [1:0]      ists;
		logic [1:0]      imask;
		logic            ack;
		logic [31:0]     dat;
		logic [NS-1:0]   tx;
		logic [NS-1:0]   oen;
	} tsicr_state_t;

	tsicr_state_t      r;
	tsicr_state_t      next_r;
	tsicr_fill_if #(.AW(CM_AW)) fif ();

	logic              req;
	logic              wr;
	logic              ctrl_wr;
	logic [15:0]       ctrl_now;
	logic [15:0]       cw;
	logic              fill_go;
	logic              e_rise;
	logic              e_fall;
	logic              eval_set;
	logic              fp_edge;
	logic              ar_edge;
	logic              drv_on;
	logic [NS-1:0]     drv;
	logic [NS/2-1:0]   drv_lo;
	logic [NS-1:0]     pin_v;
	logic [NS-1:0]     pin_oen;
	logic [31:0]       rd_val;

	// ---------------------------------------------------------------
	// Bus decode
	// ---------------------------------------------------------------
	assign req = wb_cyc_i && wb_stb_i && !r.ack;
	assign wr = req && wb_we_i;
	assign ctrl_wr = wr && (wb_adr_i == OFF_CTRL);
	assign ctrl_now = {1'b0, r.enable_indication_select, 1'b0, r.all_output_enable_mirror, 2'h0, r.arm, r.fdat,
		r.fstart, r.output_standby, r.estart, 4'h0};

	// Unused bits are never stored, so they read back as zero
	always_comb begin
		cw = ctrl_now;
		if (wb_sel_i[0]) begin
			cw[7:0] = wb_dat_i[7:0];
		end
		if (wb_sel_i[1]) begin
			cw[15:8] = wb_dat_i[15:8];
		end
	end

	always_comb begin
		rd_val = 32'h0000_0000;
		case (wb_adr_i)
			OFF_CTRL:  rd_val[15:0] = ctrl_now;
			OFF_ISTS:  rd_val[1:0] = r.ists;
			OFF_IMASK: rd_val[1:0] = r.imask;
			OFF_ALIGN: begin
				rd_val[B_ECOMP] = r.ecomp;
				rd_val[OFF_W-1:0] = r.eoff;
			end
			default:   rd_val = 32'h0000_0000;
		endcase
	end

	// ---------------------------------------------------------------
	// Fill start and pin edges
	// ---------------------------------------------------------------
	// Data and start in one write, so the data is taken with it
	assign fill_go = ctrl_wr && !fif.busy && !r.fstart && cw[B_START]
		&& cw[B_ARM];
	assign fif.start = fill_go;
	assign fif.data = cw[B_FDAT_HI:B_FDAT_LO];
	assign fp_edge = r.fp_s[1] && !r.fp_d;
	assign ar_edge = r.ar_s[1] && !r.ar_d;
	assign fif.tick = fp_edge;
	assign e_rise = ctrl_wr && !r.estart && cw[B_ESTART];
	assign e_fall = ctrl_wr && r.estart && !cw[B_ESTART];
	assign eval_set = (r.est == EV_COUNT) && ar_edge;

	// ---------------------------------------------------------------
	// Transmit pins
	// ---------------------------------------------------------------
	assign drv_on = r.de_s[1] || r.output_standby;
	assign drv = drv_on ? stream_active : '0;
	assign drv_lo = drv[NS/2-1:0];

	for (genvar i = 0; i < NS; i++) begin : g_pin
		localparam int J = (i >= NS/2) ? i - NS/2 : i;
		logic ind;
		assign ind = (i >= NS/2) && r.enable_indication_select;
		assign pin_v[i] = r.all_output_enable_mirror ? drv[i] :
			ind ? drv[J] : tx_data_in[i];
		assign pin_oen[i] = (r.all_output_enable_mirror || ind) ? 1'b0 : !drv[i];
	end

	// ---------------------------------------------------------------
	// Next state
	// ---------------------------------------------------------------
	always_comb begin
		next_r = r;
		next_r.fp_s = {r.fp_s[0], frame_pulse_pin};
		next_r.fp_d = r.fp_s[1];
		next_r.ar_s = {r.ar_s[0], align_ref_pin};
		next_r.ar_d = r.ar_s[1];
		next_r.de_s = {r.de_s[0], drive_enable_pin};
		next_r.tx = pin_v;
		next_r.oen = pin_oen;
		if (ctrl_wr) begin
			next_r.enable_indication_select = cw[B_OEI];
			next_r.all_output_enable_mirror = cw[B_AOE];
			next_r.output_standby = cw[B_OSB];
			next_r.estart = cw[B_ESTART];
			// Fill fields are frozen while a fill runs
			if (!fif.busy) begin
				next_r.arm = cw[B_ARM];
				next_r.fdat = cw[B_FDAT_HI:B_FDAT_LO];
				next_r.fstart = cw[B_START];
			end
		end
		if (fif.done) begin
			next_r.arm = 1'b0;
			next_r.fdat = 2'h0;
			next_r.fstart = 1'b0;
		end
		if (e_fall) begin
			next_r.est = EV_IDLE;
			next_r.ecomp = 1'b0;
			next_r.eoff = '0;
		end
		case (r.est)
			EV_IDLE: begin
				if (e_rise) begin
					next_r.est = EV_WAIT;
				end
			end
			EV_WAIT: begin
				if (fp_edge && !e_fall) begin
					next_r.ecnt = '0;
					next_r.est = EV_COUNT;
				end
			end
			EV_COUNT: begin
				// Capture wins over a falling start in the same cycle
				if (ar_edge) begin
					next_r.eoff = r.ecnt;
					next_r.ecomp = 1'b1;
					next_r.est = EV_IDLE;
				end else begin
					next_r.ecnt = r.ecnt + 1'b1;
				end
			end
			default: begin
				next_r.est = EV_IDLE;
			end
		endcase
		if (wr && wb_adr_i == OFF_IMASK && wb_sel_i[0]) begin
			next_r.imask = wb_dat_i[1:0];
		end
		next_r.ists = r.ists;
		if (wr && wb_adr_i == OFF_ISTS && wb_sel_i[0]) begin
			next_r.ists = r.ists & ~wb_dat_i[1:0];
		end
		// Set after clear so a same-cycle event is kept
		if (fif.done) begin
			next_r.ists[I_FILL] = 1'b1;
		end
		if (eval_set) begin
			next_r.ists[I_EVAL] = 1'b1;
		end
		next_r.ack = req;
		next_r.dat = req ? rd_val : 32'h0000_0000;
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	// ---------------------------------------------------------------
	// Outputs
	// ---------------------------------------------------------------
	tsicr_fill u_fill (
		.clk   (clk),
		.rst_n (rst_n),
		.fif   (fif.fill)
	);

	assign wb_dat_o = r.dat;
	assign wb_ack_o = r.ack;
	assign irq = |(r.ists & r.imask);
	assign transmit_stream_pins = r.tx;
	assign transmit_stream_oe_n = r.oen;
	assign cm_we = fif.cm_we;
	assign cm_addr = fif.cm_addr;
	assign cm_word = fif.cm_word;

	// ---------------------------------------------------------------
	// Checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
		else $error("ack held two cycles");
	fill_go_a: assert property (fill_go |=> fif.busy && r.fstart)
		else $error("fill did not start");
	fill_clear_a: assert property (fif.done |=> !r.arm && !r.fstart && r.fdat == 2'h0)
		else $error("fill bits not cleared");
	standby_a: assert property (!drv_on && !r.all_output_enable_mirror && !r.enable_indication_select |=> &transmit_stream_oe_n)
		else $error("drivers on in standby");
	mirror_a: assert property (r.all_output_enable_mirror |=> transmit_stream_oe_n == '0 && transmit_stream_pins == $past(drv))
		else $error("mirror pins wrong");
	indicate_a: assert property (r.enable_indication_select && !r.all_output_enable_mirror |=> transmit_stream_pins[NS-1:NS/2] == $past(drv_lo))
		else $error("indicator pins wrong");
	normal_a: assert property (!r.all_output_enable_mirror && !r.enable_indication_select |=> transmit_stream_pins == $past(tx_data_in))
		else $error("data pins wrong");
	eval_go_a: assert property (e_rise && r.est == EV_IDLE |=> r.est == EV_WAIT)
		else $error("evaluation did not start");
	eval_stop_a: assert property (eval_set |=> r.ecomp && r.est == EV_IDLE)
		else $error("evaluation did not stop");
	eval_clr_a: assert property (e_fall && !eval_set |=> !r.ecomp && r.eoff == '0)
		else $error("evaluation result not cleared");
	irq_fill_a: assert property (fif.done && r.imask[I_FILL] |=> irq)
		else $error("fill interrupt missing");

	cov_fill_c: cover property (fill_go ##[1:1000] fif.busy);
	cov_eval_c: cover property (eval_set);
	cov_irq_c: cover property (irq);

endmodule // tsicr_top

// [inc/tsicr_pkg.sv]
// Constants and types shared by the switch control register block
package tsicr_pkg;

	// ---------------------------------------------------------------
	// Bus map (byte addresses)
	// ---------------------------------------------------------------
	localparam int          WB_AW      = 8;
	localparam logic [7:0]  OFF_CTRL   = 8'h00;
	localparam logic [7:0]  OFF_ISTS   = 8'h04;
	localparam logic [7:0]  OFF_IMASK  = 8'h08;
	localparam logic [7:0]  OFF_ALIGN  = 8'h0C;

	// ---------------------------------------------------------------
	// Control word fields and reset values
	// ---------------------------------------------------------------
	localparam int          B_OEI      = 14;
	localparam int          B_AOE      = 12;
	localparam int          B_ARM      = 9;
	localparam int          B_FDAT_HI  = 8;
	localparam int          B_FDAT_LO  = 7;
	localparam int          B_START    = 6;
	localparam int          B_OSB      = 5;
	localparam int          B_ESTART   = 4;
	localparam logic [15:0] CTRL_RST   = 16'h0000;
	localparam int          B_ECOMP    = 13;
	localparam int          I_FILL     = 0;
	localparam int          I_EVAL     = 1;
	localparam logic [1:0]  IRQ_RST    = 2'h0;

	// ---------------------------------------------------------------
	// Sizes and counts
	// ---------------------------------------------------------------
	localparam int          NSTREAM    = 32;
	localparam int          CM_AW      = 14;
	localparam int          CM_DW      = 16;
	localparam int          OFF_W      = 13;
	localparam logic [1:0]  FILL_FRAMES = 2'h2;

	typedef enum logic [1:0] {FL_IDLE, FL_WAIT, FL_RUN, FL_DONE}
		tsicr_fill_st_t;
	typedef enum logic [1:0] {EV_IDLE, EV_WAIT, EV_COUNT}
		tsicr_eval_st_t;

endpackage

// [inc/tsicr_fill_if.sv]
// Link between the control register and the block fill engine
`timescale 1ns/10ps
interface tsicr_fill_if #(parameter int AW = 14);
	logic            start;
	logic [1:0]      data;
	logic            tick;
	logic            busy;
	logic            done;
	logic            cm_we;
	logic [AW-1:0]   cm_addr;
	logic [15:0]     cm_word;

	modport ctrl (output start, data, tick,
		input busy, done, cm_we, cm_addr, cm_word);
	modport fill (input start, data, tick,
		output busy, done, cm_we, cm_addr, cm_word);
endinterface

// [verilog/tsicr_fill.sv]
// Connection memory block fill engine
`timescale 1ns/10ps
module tsicr_fill
	import tsicr_pkg::*;
(
	input  wire logic   clk,
	input  wire logic   rst_n,
	tsicr_fill_if.fill  fif
);
	localparam int AW = CM_AW;

	typedef struct packed {
		tsicr_fill_st_t st;
		logic [1:0]     fc;
		logic           wdone;
		logic [AW-1:0]  addr;
		logic [1:0]     dat;
	} tsicr_fstate_t;

	tsicr_fstate_t r;
	tsicr_fstate_t next_r;
	logic          we;

	assign we = (r.st == FL_RUN) && !r.wdone;
	assign fif.busy = (r.st != FL_IDLE);
	assign fif.done = (r.st == FL_DONE);
	assign fif.cm_we = we;
	assign fif.cm_addr = r.addr;
	assign fif.cm_word = {r.dat, 14'h0000};

	always_comb begin
		next_r = r;
		case (r.st)
			FL_IDLE: begin
				if (fif.start) begin
					next_r.dat = fif.data;
					next_r.fc = 2'h0;
					next_r.wdone = 1'b0;
					next_r.addr = '0;
					next_r.st = FL_WAIT;
				end
			end
			// Start on a frame edge so two whole frames are spanned
			FL_WAIT: begin
				if (fif.tick) begin
					next_r.st = FL_RUN;
				end
			end
			FL_RUN: begin
				if (we) begin
					next_r.addr = r.addr + 1'b1;
					if (&r.addr) begin
						next_r.wdone = 1'b1;
					end
				end
				if (fif.tick && r.fc != FILL_FRAMES) begin
					next_r.fc = r.fc + 2'h1;
				end
				if (r.fc == FILL_FRAMES && r.wdone) begin
					next_r.st = FL_DONE;
				end
			end
			FL_DONE: begin
				next_r.st = FL_IDLE;
			end
			default: begin
				next_r.st = FL_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			r <= '0;
		end else begin
			r <= next_r;
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	fill_word_a: assert property (we && !(&r.addr)
		|=> we && r.addr == $past(r.addr) + 1'b1)
		else $error("fill walk skipped a word");
	fill_span_a: assert property (fif.done |-> $past(r.fc) == FILL_FRAMES)
		else $error("fill ended before two frames");
	fill_data_a: assert property (fif.start && !fif.busy |=> r.dat == $past(fif.data))
		else $error("fill data not latched");
	fill_cov_c: cover property (fif.done);

endmodule // tsicr_fill

// [tb/tb_tsi_control_register.sv]
// Self-checking bench for the switch control register block
`timescale 1ns/10ps
module tb_tsi_control_register
	import tsicr_pkg::*;
;
	// ---------------------------------------------------------------
	// Signals
	// ---------------------------------------------------------------
	logic             clk;
	logic             rst_n;
	logic             wb_cyc_i;
	logic             wb_stb_i;
	logic             wb_we_i;
	logic [WB_AW-1:0] wb_adr_i;
	logic [3:0]       wb_sel_i;
	logic [31:0]      wb_dat_i;
	logic [31:0]      wb_dat_o;
	logic             wb_ack_o;
	logic             irq;
	logic             frame_pulse_pin;
	logic             align_ref_pin;
	logic             drive_enable_pin;
	logic [31:0]      tx_data_in;
	logic [31:0]      stream_active;
	logic [31:0]      transmit_stream_pins;
	logic [31:0]      transmit_stream_oe_n;
	logic             cm_we;
	logic [CM_AW-1:0] cm_addr;
	logic [CM_DW-1:0] cm_word;
	int               n_mismatch;
	int               checks_done;

	tsicr_top #(.NS(32)) u_dut (
		.clk(clk), .rst_n(rst_n), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
		.wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
		.wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
		.irq(irq), .frame_pulse_pin(frame_pulse_pin),
		.align_ref_pin(align_ref_pin), .drive_enable_pin(drive_enable_pin),
		.tx_data_in(tx_data_in), .stream_active(stream_active),
		.transmit_stream_pins(transmit_stream_pins),
		.transmit_stream_oe_n(transmit_stream_oe_n),
		.cm_we(cm_we), .cm_addr(cm_addr), .cm_word(cm_word));

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	// ---------------------------------------------------------------
	// Shared tasks
	// ---------------------------------------------------------------
	task automatic close_out;
		if (n_mismatch == 0 && checks_done > 0) begin
			$display("No errors found");
		end else begin
			$display("Errors were found");
		end
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		checks_done++;
		if (got !== exp) begin
			n_mismatch++;
			$display("BAD %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	// Classic cycle; ack sampled at the edge, then released
	task automatic wb(input logic we, input logic [7:0] adr,
		input logic [31:0] d, output logic [31:0] q);
		int k;
		k = 0;
		@(posedge clk);
		wb_cyc_i <= 1'b1;
		wb_stb_i <= 1'b1;
		wb_we_i  <= we;
		wb_sel_i <= 4'h3;
		wb_adr_i <= adr;
		wb_dat_i <= d;
		do begin
			@(posedge clk);
			k++;
		end while (wb_ack_o !== 1'b1 && k < 20);
		q = wb_dat_o;
		chk({31'h0, wb_ack_o}, 32'h0000_0001);
		wb_cyc_i <= 1'b0;
		wb_stb_i <= 1'b0;
		wb_we_i  <= 1'b0;
	endtask

	task automatic wr(input logic [7:0] adr, input logic [31:0] d);
		logic [31:0] q;
		wb(1'b1, adr, d, q);
	endtask

	task automatic rd(input logic [7:0] adr, input logic [31:0] exp);
		logic [31:0] q;
		wb(1'b0, adr, 32'h0000_0000, q);
		chk(q, exp);
	endtask

	task automatic pulse_frame;
		@(posedge clk);
		frame_pulse_pin <= 1'b1;
		cyc(2);
		frame_pulse_pin <= 1'b0;
	endtask

	// ---------------------------------------------------------------
	// Scenarios
	// ---------------------------------------------------------------
	task automatic t_reset_map;
		rd(OFF_CTRL, 32'h0000_0000);
		rd(OFF_ISTS, 32'h0000_0000);
		rd(OFF_ALIGN, 32'h0000_0000);
		wr(OFF_CTRL, 32'h0000_AC0F);
		rd(OFF_CTRL, 32'h0000_0000);
		wr(8'h10, 32'h0000_FFFF);
		rd(8'h10, 32'h0000_0000);
	endtask

	task automatic t_pins;
		wr(OFF_CTRL, 32'h0000_0000);
		cyc(4);
		chk(transmit_stream_pins, tx_data_in);
		chk(transmit_stream_oe_n, 32'hFFFF_FFFF);
		wr(OFF_CTRL, 32'h0000_0020);
		cyc(4);
		chk(transmit_stream_oe_n, ~stream_active);
		chk(transmit_stream_pins, tx_data_in);
		wr(OFF_CTRL, 32'h0000_0000);
		drive_enable_pin <= 1'b1;
		cyc(6);
		chk(transmit_stream_oe_n, ~stream_active);
		wr(OFF_CTRL, 32'h0000_4000);
		cyc(4);
		chk(transmit_stream_pins, {stream_active[15:0], tx_data_in[15:0]});
		chk({16'h0, transmit_stream_oe_n[31:16]}, 32'h0000_0000);
		wr(OFF_CTRL, 32'h0000_1000);
		cyc(4);
		chk(transmit_stream_pins, stream_active);
		chk(transmit_stream_oe_n, 32'h0000_0000);
		wr(OFF_CTRL, 32'h0000_0000);
		drive_enable_pin <= 1'b0;
	endtask

	task automatic t_fill;
		int n;
		int badw;
		logic [31:0] first;
		logic [31:0] last;
		n = 0;
		badw = 0;
		first = 32'hFFFF_FFFF;
		last = 32'h0000_0000;
		wr(OFF_IMASK, 32'h0000_0000);
		wr(OFF_CTRL, 32'h0000_0340);
		rd(OFF_CTRL, 32'h0000_0340);
		fork
			begin
				pulse_frame();
				cyc(9000);
				pulse_frame();
				cyc(8000);
				rd(OFF_CTRL, 32'h0000_0340);
				cyc(1000);
				pulse_frame();
				cyc(20);
			end
			begin
				repeat (18100) begin
					@(posedge clk);
					if (cm_we === 1'b1) begin
						if (n == 0) first = {18'h0, cm_addr};
						last = {18'h0, cm_addr};
						n++;
						if (cm_word !== 16'h8000) badw++;
					end
				end
			end
		join
		chk(n, 32'h0000_4000);
		chk(badw, 32'h0000_0000);
		chk(first, 32'h0000_0000);
		chk(last, 32'h0000_3FFF);
		rd(OFF_CTRL, 32'h0000_0000);
		rd(OFF_ISTS, 32'h0000_0001);
		@(negedge clk);
		chk({31'h0, irq}, 32'h0000_0000);
		wr(OFF_IMASK, 32'h0000_0001);
		@(negedge clk);
		chk({31'h0, irq}, 32'h0000_0001);
		wr(OFF_ISTS, 32'h0000_0001);
		rd(OFF_ISTS, 32'h0000_0000);
		@(negedge clk);
		chk({31'h0, irq}, 32'h0000_0000);
	endtask

	task automatic t_eval;
		wr(OFF_IMASK, 32'h0000_0002);
		wr(OFF_CTRL, 32'h0000_0010);
		pulse_frame();
		cyc(48);
		align_ref_pin <= 1'b1;
		cyc(2);
		align_ref_pin <= 1'b0;
		cyc(8);
		rd(OFF_ALIGN, 32'h0000_2031);
		@(negedge clk);
		chk({31'h0, irq}, 32'h0000_0001);
		@(posedge clk);
		align_ref_pin <= 1'b1;
		cyc(2);
		align_ref_pin <= 1'b0;
		cyc(8);
		rd(OFF_ALIGN, 32'h0000_2031);
		wr(OFF_CTRL, 32'h0000_0000);
		rd(OFF_ALIGN, 32'h0000_0000);
		rd(OFF_ISTS, 32'h0000_0002);
		wr(OFF_ISTS, 32'h0000_0002);
	endtask

	// ---------------------------------------------------------------
	// Sequence and watchdog
	// ---------------------------------------------------------------
	initial begin
		n_mismatch = 0;
		checks_done = 0;
		rst_n = 1'b0;
		{wb_cyc_i, wb_stb_i, wb_we_i} = 3'h0;
		wb_adr_i = 8'h00;
		wb_sel_i = 4'h3;
		wb_dat_i = 32'h0000_0000;
		{frame_pulse_pin, align_ref_pin, drive_enable_pin} = 3'h0;
		tx_data_in = 32'h1234_5678;
		stream_active = 32'h3C96_A5C3;
		cyc(12);
		rst_n <= 1'b1;
		t_reset_map();
		t_pins();
		t_fill();
		t_eval();
		close_out();
	end

	// Whole run needs about 18.3k cycles
	initial begin
		cyc(40000);
		n_mismatch++;
		close_out();
	end
endmodule // tb_tsi_control_register
